// ===== hdl/mtt_pkg.sv
// Constants, types and field layouts for the multi-turn position tracker.
// Assumes a single 100 MHz clock and that a power cycle is seen as a reset.
package mtt_pkg;

  localparam int TURN_W = 16;
  // Limit value that selects the signed full-range count
  localparam logic [15:0] LIMIT_DEFAULT = 16'hffff;
  // Encoder-side stored limit as shipped, equal to the drive default
  localparam logic [15:0] ENC_LIMIT_DEFAULT = 16'hffff;
  localparam logic USAGE_ABSOLUTE = 1'h0;
  localparam logic USAGE_INCREMENTAL = 1'h1;
  localparam logic USAGE_RESET = 1'h0;
  localparam logic [15:0] TURN_RESET = 16'h0000;

  // Alarm code pin levels: asserted is low
  localparam logic CODE_ON = 1'h0;
  localparam logic CODE_OFF = 1'h1;

  // Timing
  localparam longint CLK_FREQ_HZ = 100000000;
  localparam longint BLANK_PWRUP_S = 3;
  localparam longint BLANK_PWRUP_CYC = BLANK_PWRUP_S * CLK_FREQ_HZ;
  localparam longint BLANK_MOMENT_MS = 10;
  localparam longint BLANK_MOMENT_CYC = (BLANK_MOMENT_MS * CLK_FREQ_HZ) / 1000;
  localparam int BLANK_CNT_W = 32;

  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic usage_select;
    logic [15:0] limit;
  } mtt_cfg_t;

  typedef struct packed {
    logic first;
    logic second;
    logic third;
  } mtt_alarm_code_t;

  // Encoder and connector pins gathered for the synchroniser, bit order fixed below
  typedef struct packed {
    logic rev_pos;
    logic rev_neg;
    logic backup_loss;
    logic checksum_err;
    logic monitor_alarm;
    logic handheld;
  } mtt_pins_t;

  localparam int PINS_W = $bits(mtt_pins_t);

endpackage

// ===== hdl/mtt_sync.sv
// Three-stage synchroniser with agreement filter for a vector of pins.
// Assumes inputs are asynchronous levels; output is a registered level.
`timescale 1ns/100ps
`default_nettype none
module mtt_sync
  import mtt_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] init_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;
  logic init_done_q;

  // A change counts only when stages two and three agree
  always_comb begin
    level_d = level_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        level_d[i] = s3_q[i];
      end
    end
    if (!init_done_q) begin
      level_d = init_in;
    end
  end

  // Stage one feeds only stage two
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
      init_done_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      init_done_q <= 1'b1;
    end
  end

  assign level_out = level_q;

endmodule
`default_nettype wire

// ===== hdl/mtt_tracker.sv
// Multi-turn position tracker: turn counting, limit compare and alarms.
// Assumes encoder pins are asynchronous and command pulses share the clock.
`timescale 1ns/100ps
`default_nettype none
module mtt_tracker
  import mtt_pkg::*;
#(
  parameter longint PWRUP_BLANK_CYC = BLANK_PWRUP_CYC,
  parameter longint MOMENT_BLANK_CYC = BLANK_MOMENT_CYC
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire mtt_cfg_t cfg_in,
  input wire logic [15:0] enc_limit_in,
  input wire logic enc_limit_valid_in,
  input wire logic rev_pos_in,
  input wire logic rev_neg_in,
  input wire logic backup_loss_in,
  input wire logic checksum_err_in,
  input wire logic enc_monitor_alarm_in,
  input wire logic handheld_unit_connector_in,
  input wire logic servo_on_in,
  input wire logic encoder_setup_function_in,
  input wire logic encoder_limit_write_function_in,
  input wire logic alarm_reset_in,
  input wire logic fieldbus_trace_in,
  input wire logic param_access_in,
  output logic ready_out,
  output logic absolute_mode_out,
  output logic [15:0] turn_count_out,
  output logic count_signed_out,
  output mtt_alarm_code_t alarm_code_out,
  output logic limit_mismatch_alarm_out,
  output logic backup_alarm_out,
  output logic checksum_alarm_out,
  output logic monitor_alarm_out,
  output logic setup_ack_out,
  output logic setup_reject_out,
  output logic alarm_reset_refused_out,
  output logic limit_wr_strobe_out,
  output logic [15:0] limit_wr_data_out,
  output logic limit_wr_reject_out,
  output logic indicators_on_out
);

  typedef enum logic [1:0] {ST_CAPTURE, ST_COMPARE, ST_RUN} mtt_state_t;

  // Counts that the blank counter cannot hold would silently truncate
  if (PWRUP_BLANK_CYC < 1 || PWRUP_BLANK_CYC >= (64'h1 << BLANK_CNT_W)) begin : g_chk_pwrup
    $error("power-up blank count out of range");
  end
  if (MOMENT_BLANK_CYC < 1 || MOMENT_BLANK_CYC >= (64'h1 << BLANK_CNT_W)) begin : g_chk_moment
    $error("momentary blank count out of range");
  end

  localparam logic [BLANK_CNT_W-1:0] PWRUP_CNT = PWRUP_BLANK_CYC[BLANK_CNT_W-1:0];
  localparam logic [BLANK_CNT_W-1:0] MOMENT_CNT = MOMENT_BLANK_CYC[BLANK_CNT_W-1:0];

  // One revolution step under the latched wrap rule
  function automatic logic [15:0] turn_step(input logic [15:0] cnt,
                                             input logic [15:0] lim,
                                             input logic wrap_en,
                                             input logic dir_pos);
    logic [15:0] r;
    r = cnt;
    if (!wrap_en) begin
      r = dir_pos ? 16'(cnt + 16'h0001) : 16'(cnt - 16'h0001);
    end else if (dir_pos) begin
      r = (cnt >= lim) ? 16'h0000 : 16'(cnt + 16'h0001);
    end else begin
      r = (cnt == 16'h0000) ? lim : 16'(cnt - 16'h0001);
    end
    return r;
  endfunction

  // Synchronised encoder and connector pins
  mtt_pins_t pins_raw;
  mtt_pins_t pins_s;
  mtt_pins_t pins_prev_q;
  mtt_pins_t pins_prev_d;
  mtt_pins_t pins_init;

  assign pins_raw = '{rev_pos: rev_pos_in, rev_neg: rev_neg_in,
                      backup_loss: backup_loss_in, checksum_err: checksum_err_in,
                      monitor_alarm: enc_monitor_alarm_in,
                      handheld: handheld_unit_connector_in};
  assign pins_init = '0;

  mtt_sync #(
    .WIDTH(PINS_W)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .pin_in(pins_raw),
    .init_in(pins_init),
    .level_out(pins_s)
  );

  // Rising edges of the filtered levels
  logic rev_pos_evt;
  logic rev_neg_evt;
  logic backup_evt;
  logic checksum_evt;
  logic monitor_evt;

  assign pins_prev_d = pins_s;
  assign rev_pos_evt = pins_s.rev_pos & ~pins_prev_q.rev_pos;
  assign rev_neg_evt = pins_s.rev_neg & ~pins_prev_q.rev_neg;
  assign backup_evt = pins_s.backup_loss & ~pins_prev_q.backup_loss;
  assign checksum_evt = pins_s.checksum_err & ~pins_prev_q.checksum_err;
  assign monitor_evt = pins_s.monitor_alarm & ~pins_prev_q.monitor_alarm;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pins_prev_q <= '0;
    end else begin
      pins_prev_q <= pins_prev_d;
    end
  end

  // Power-up sequencing and latched configuration
  mtt_state_t state_q;
  mtt_state_t state_d;
  mtt_cfg_t cfg_q;
  mtt_cfg_t cfg_d;
  logic [15:0] enc_limit_q;
  logic [15:0] enc_limit_d;
  logic wrap_en;
  logic absolute;
  logic limit_wr_strobe_d;

  // Settings are caught once after reset release, so later edits wait for power
  always_comb begin
    state_d = state_q;
    cfg_d = cfg_q;
    enc_limit_d = enc_limit_q;
    case (state_q)
      ST_CAPTURE: begin
        cfg_d = cfg_in;
        state_d = ST_COMPARE;
      end
      ST_COMPARE: begin
        if (enc_limit_valid_in) begin
          enc_limit_d = enc_limit_in;
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (limit_wr_strobe_d) begin
          enc_limit_d = cfg_q.limit;
        end
      end
      default: begin
        state_d = ST_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_CAPTURE;
      cfg_q <= '{usage_select: USAGE_RESET, limit: LIMIT_DEFAULT};
      enc_limit_q <= ENC_LIMIT_DEFAULT;
    end else begin
      state_q <= state_d;
      cfg_q <= cfg_d;
      enc_limit_q <= enc_limit_d;
    end
  end

  // Incremental use drops the wrap limit and the limit compare
  assign absolute = (cfg_q.usage_select == USAGE_ABSOLUTE);
  assign wrap_en = absolute && (cfg_q.limit != LIMIT_DEFAULT);

  // Turn counter and alarm flags
  logic [15:0] turn_q;
  logic [15:0] turn_d;
  logic mismatch_q;
  logic mismatch_d;
  logic backup_q;
  logic backup_d;
  logic checksum_q;
  logic checksum_d;
  logic monitor_q;
  logic monitor_d;
  logic setup_ack_q;
  logic setup_ack_d;
  logic setup_rej_q;
  logic setup_rej_d;
  logic rst_refused_q;
  logic rst_refused_d;
  logic limit_wr_strobe_q;
  logic limit_wr_rej_q;
  logic limit_wr_rej_d;
  logic [15:0] limit_wr_data_q;
  logic [15:0] limit_wr_data_d;
  logic setup_ok;
  logic running;

  assign running = (state_q == ST_RUN);
  assign setup_ok = running && encoder_setup_function_in && !servo_on_in;

  // Alarm sets win over same-cycle clears, so an event is never lost
  always_comb begin
    turn_d = turn_q;
    mismatch_d = mismatch_q;
    backup_d = backup_q;
    checksum_d = checksum_q;
    monitor_d = monitor_q | monitor_evt;
    setup_ack_d = 1'b0;
    setup_rej_d = 1'b0;
    rst_refused_d = 1'b0;
    limit_wr_strobe_d = 1'b0;
    limit_wr_rej_d = 1'b0;
    limit_wr_data_d = limit_wr_data_q;
    if (running && (rev_pos_evt ^ rev_neg_evt)) begin
      turn_d = turn_step(turn_q, cfg_q.limit, wrap_en, rev_pos_evt);
    end
    if (state_q == ST_COMPARE && enc_limit_valid_in && absolute) begin
      mismatch_d = (enc_limit_in != cfg_q.limit);
    end
    if (running && encoder_setup_function_in) begin
      setup_ack_d = setup_ok;
      setup_rej_d = !setup_ok;
    end
    if (setup_ok) begin
      backup_d = 1'b0;
      checksum_d = 1'b0;
      turn_d = TURN_RESET;
    end
    if (backup_evt) begin
      backup_d = 1'b1;
    end
    if (checksum_evt) begin
      checksum_d = 1'b1;
    end
    // Ordinary reset leaves encoder data alarms standing and says so
    if (alarm_reset_in && (backup_q || checksum_q)) begin
      rst_refused_d = 1'b1;
    end
    if (running && encoder_limit_write_function_in) begin
      if (mismatch_q) begin
        limit_wr_strobe_d = 1'b1;
        limit_wr_data_d = cfg_q.limit;
        mismatch_d = 1'b0;
      end else begin
        limit_wr_rej_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      turn_q <= TURN_RESET;
      mismatch_q <= 1'b0;
      backup_q <= 1'b0;
      checksum_q <= 1'b0;
      monitor_q <= 1'b0;
      setup_ack_q <= 1'b0;
      setup_rej_q <= 1'b0;
      rst_refused_q <= 1'b0;
      limit_wr_strobe_q <= 1'b0;
      limit_wr_rej_q <= 1'b0;
      limit_wr_data_q <= LIMIT_DEFAULT;
    end else begin
      turn_q <= turn_d;
      mismatch_q <= mismatch_d;
      backup_q <= backup_d;
      checksum_q <= checksum_d;
      monitor_q <= monitor_d;
      setup_ack_q <= setup_ack_d;
      setup_rej_q <= setup_rej_d;
      rst_refused_q <= rst_refused_d;
      limit_wr_strobe_q <= limit_wr_strobe_d;
      limit_wr_rej_q <= limit_wr_rej_d;
      limit_wr_data_q <= limit_wr_data_d;
    end
  end

  // Alarm code pins, registered straight from the next mismatch state
  mtt_alarm_code_t code_q;
  mtt_alarm_code_t code_d;

  always_comb begin
    code_d = '{first: CODE_OFF, second: CODE_OFF, third: CODE_OFF};
    if (mismatch_d) begin
      code_d = '{first: CODE_ON, second: CODE_OFF, third: CODE_ON};
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      code_q <= '{first: CODE_OFF, second: CODE_OFF, third: CODE_OFF};
    end else begin
      code_q <= code_d;
    end
  end

  // Front-panel blanking; the counter keeps the longer of any pending windows
  logic [BLANK_CNT_W-1:0] blank_cnt_q;
  logic [BLANK_CNT_W-1:0] blank_cnt_d;
  logic ind_on_q;
  logic ind_on_d;

  always_comb begin
    blank_cnt_d = blank_cnt_q;
    if (blank_cnt_q != '0) begin
      blank_cnt_d = blank_cnt_q - 1'b1;
    end
    if (param_access_in && blank_cnt_d < MOMENT_CNT) begin
      blank_cnt_d = MOMENT_CNT;
    end
    ind_on_d = !(pins_s.handheld || fieldbus_trace_in || blank_cnt_d != '0);
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      blank_cnt_q <= PWRUP_CNT;
      ind_on_q <= 1'b0;
    end else begin
      blank_cnt_q <= blank_cnt_d;
      ind_on_q <= ind_on_d;
    end
  end

  // Status mirrors, all from flip-flops
  logic ready_q;
  logic abs_q;
  logic signed_q;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ready_q <= 1'b0;
      abs_q <= 1'b0;
      signed_q <= 1'b0;
    end else begin
      ready_q <= (state_d == ST_RUN);
      abs_q <= (cfg_d.usage_select == USAGE_ABSOLUTE);
      signed_q <= !((cfg_d.usage_select == USAGE_ABSOLUTE) && (cfg_d.limit != LIMIT_DEFAULT));
    end
  end

  assign ready_out = ready_q;
  assign absolute_mode_out = abs_q;
  assign turn_count_out = turn_q;
  assign count_signed_out = signed_q;
  assign alarm_code_out = code_q;
  assign limit_mismatch_alarm_out = mismatch_q;
  assign backup_alarm_out = backup_q;
  assign checksum_alarm_out = checksum_q;
  assign monitor_alarm_out = monitor_q;
  assign setup_ack_out = setup_ack_q;
  assign setup_reject_out = setup_rej_q;
  assign alarm_reset_refused_out = rst_refused_q;
  assign limit_wr_strobe_out = limit_wr_strobe_q;
  assign limit_wr_data_out = limit_wr_data_q;
  assign limit_wr_reject_out = limit_wr_rej_q;
  assign indicators_on_out = ind_on_q;

endmodule
`default_nettype wire

// ===== dv/mtt_tracker_monitor.sv
// Concurrent checks on the tracker's ports, bound into every tracker instance.
// Assumes one clock domain and cfg_in held steady while the tracker runs.
`timescale 1ns/100ps
`default_nettype none
module mtt_tracker_monitor
  import mtt_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire mtt_cfg_t cfg_in,
  input wire logic servo_on_in,
  input wire logic encoder_setup_function_in,
  input wire logic encoder_limit_write_function_in,
  input wire logic alarm_reset_in,
  input wire logic fieldbus_trace_in,
  input wire logic ready_out,
  input wire logic [15:0] turn_count_out,
  input wire logic count_signed_out,
  input wire mtt_alarm_code_t alarm_code_out,
  input wire logic limit_mismatch_alarm_out,
  input wire logic backup_alarm_out,
  input wire logic monitor_alarm_out,
  input wire logic setup_ack_out,
  input wire logic setup_reject_out,
  input wire logic alarm_reset_refused_out,
  input wire logic limit_wr_strobe_out,
  input wire logic limit_wr_reject_out,
  input wire logic indicators_on_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // Accepted write: strobe out, alarm gone, code pins back to idle
  sequence s_wr_ok;
    limit_wr_strobe_out && !limit_mismatch_alarm_out && (alarm_code_out == 3'h7);
  endsequence
  sequence s_wr_req;
    encoder_limit_write_function_in && ready_out;
  endsequence
  a_mismatch_code: assert property (limit_mismatch_alarm_out |-> alarm_code_out == 3'h2)
    else $error("mismatch code pins wrong");
  a_setup_refused: assert property (encoder_setup_function_in && ready_out && servo_on_in
    |=> setup_reject_out && !setup_ack_out)
    else $error("setup not refused with servo on");
  a_setup_taken: assert property (encoder_setup_function_in && ready_out && !servo_on_in
    |=> setup_ack_out && !setup_reject_out)
    else $error("setup not taken with servo off");
  a_reset_keeps: assert property (alarm_reset_in && backup_alarm_out
    && !encoder_setup_function_in |=> backup_alarm_out && alarm_reset_refused_out)
    else $error("backup alarm cleared by alarm reset");
  a_write_refused: assert property (s_wr_req and !limit_mismatch_alarm_out
    |=> limit_wr_reject_out && !limit_wr_strobe_out)
    else $error("limit write not refused");
  a_write_clears: assert property (s_wr_req and limit_mismatch_alarm_out |=> s_wr_ok)
    else $error("limit write did not clear mismatch");
  a_monitor_sticky: assert property (monitor_alarm_out |=> monitor_alarm_out[*8])
    else $error("monitor alarm dropped without power cycle");
  a_count_range: assert property (ready_out && !count_signed_out
    |-> turn_count_out <= cfg_in.limit)
    else $error("turn count above limit");
  a_step_one: assert property (ready_out && $past(ready_out) && count_signed_out && !setup_ack_out
    && $changed(turn_count_out)
    |-> (turn_count_out - $past(turn_count_out)) inside {16'h0001, 16'hffff})
    else $error("turn count moved by more than one");
  a_trace_blank: assert property (fieldbus_trace_in |=> !indicators_on_out)
    else $error("indicators lit during trace");
endmodule
bind mtt_tracker mtt_tracker_monitor MON (.ref_clk_in, .nrst_in, .cfg_in, .servo_on_in,
  .encoder_setup_function_in, .encoder_limit_write_function_in, .alarm_reset_in,
  .fieldbus_trace_in, .ready_out, .turn_count_out, .count_signed_out, .alarm_code_out,
  .limit_mismatch_alarm_out, .backup_alarm_out, .monitor_alarm_out, .setup_ack_out,
  .setup_reject_out, .alarm_reset_refused_out, .limit_wr_strobe_out, .limit_wr_reject_out,
  .indicators_on_out);
`default_nettype wire

// ===== dv/mtt_enc_model.sv
// Encoder and front-pin model: stored limit, revolution and alarm pins.
// Assumes the bench sets alarm and handheld pins through pins_q directly.
`timescale 1ns/100ps
`default_nettype none
module mtt_enc_model
  import mtt_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic limit_wr_strobe_in,
  input wire logic [15:0] limit_wr_data_in,
  output logic [15:0] enc_limit_out,
  output logic enc_limit_valid_out,
  output mtt_pins_t pins_out
);
  logic [15:0] stored_q = ENC_LIMIT_DEFAULT;
  logic [1:0] age_q;
  mtt_pins_t pins_q = '0;
  // Stored limit lives in the encoder, so a drive reset keeps it
  always @(posedge ref_clk_in) if (limit_wr_strobe_in) stored_q <= limit_wr_data_in;
  // Limit is offered from the second edge after release
  always @(posedge ref_clk_in or negedge nrst_in)
    if (!nrst_in) age_q <= 2'h0;
    else if (age_q != 2'h2) age_q <= age_q + 2'h1;
  assign enc_limit_valid_out = (age_q == 2'h2);
  assign enc_limit_out = stored_q;
  assign pins_out = pins_q;
  // One revolution: pin held long enough to pass the filter, then quiet
  task automatic turn(input logic pos);
    @(posedge ref_clk_in);
    #1;
    if (pos) pins_q.rev_pos = 1'h1; else pins_q.rev_neg = 1'h1;
    repeat (4) @(posedge ref_clk_in);
    #1;
    pins_q.rev_pos = 1'h0;
    pins_q.rev_neg = 1'h0;
    repeat (6) @(posedge ref_clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== dv/mtt_tracker_tb.sv
// Self-checking bench for the multi-turn tracker with the encoder model.
// Assumes shortened blank counts; each power cycle is a reset pulse.
`timescale 1ns/100ps
`default_nettype none
module mtt_tracker_tb;
  import mtt_pkg::*;
  logic ref_clk_in, nrst_in, servo_on_in, fieldbus_trace_in;
  logic [3:0] cmd;
  mtt_cfg_t cfg_in;
  logic [15:0] enc_limit_in, turn_count_out, limit_wr_data_out;
  logic enc_limit_valid_in, ready_out, absolute_mode_out, count_signed_out;
  logic limit_mismatch_alarm_out, backup_alarm_out, checksum_alarm_out, monitor_alarm_out;
  logic setup_ack_out, setup_reject_out, alarm_reset_refused_out, limit_wr_strobe_out;
  logic limit_wr_reject_out, indicators_on_out;
  mtt_alarm_code_t alarm_code_out;
  mtt_pins_t pins;
  int n_fail = 0;
  int n_checks = 0;
  // Revolution rows: bit 16 is direction, low half the expected count
  logic [16:0] rows [7] = '{17'h00003, 17'h10000, 17'h10001, 17'h10002, 17'h10003,
    17'h10000, 17'h10001};
  mtt_tracker #(.PWRUP_BLANK_CYC(20), .MOMENT_BLANK_CYC(5)) DUT (.ref_clk_in, .nrst_in,
    .cfg_in, .enc_limit_in, .enc_limit_valid_in, .rev_pos_in(pins.rev_pos),
    .rev_neg_in(pins.rev_neg), .backup_loss_in(pins.backup_loss),
    .checksum_err_in(pins.checksum_err), .enc_monitor_alarm_in(pins.monitor_alarm),
    .handheld_unit_connector_in(pins.handheld), .servo_on_in,
    .encoder_setup_function_in(cmd[0]), .encoder_limit_write_function_in(cmd[1]),
    .alarm_reset_in(cmd[2]), .fieldbus_trace_in, .param_access_in(cmd[3]), .ready_out,
    .absolute_mode_out, .turn_count_out, .count_signed_out, .alarm_code_out,
    .limit_mismatch_alarm_out, .backup_alarm_out, .checksum_alarm_out, .monitor_alarm_out,
    .setup_ack_out, .setup_reject_out, .alarm_reset_refused_out, .limit_wr_strobe_out,
    .limit_wr_data_out, .limit_wr_reject_out, .indicators_on_out);
  mtt_enc_model ENC (.ref_clk_in, .nrst_in, .limit_wr_strobe_in(limit_wr_strobe_out),
    .limit_wr_data_in(limit_wr_data_out), .enc_limit_out(enc_limit_in),
    .enc_limit_valid_out(enc_limit_valid_in), .pins_out(pins));
  // 100 MHz clock
  always #5 ref_clk_in = ~ref_clk_in;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One-cycle command pulse; the answer is visible when this returns
  task automatic go(input logic [3:0] c);
    @(posedge ref_clk_in);
    #1 cmd = c;
    @(posedge ref_clk_in);
    #1 cmd = 4'h0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // Power cycle: reset 10 cycles, reset values, then compare finishes
  task automatic pwr(input logic u, input logic [15:0] l);
    nrst_in = 1'h0;
    cfg_in = '{usage_select: u, limit: l};
    wait_cyc(10);
    chk(alarm_code_out, 16'h7, "reset code");
    chk(limit_wr_data_out, 16'hffff, "reset data");
    chk({ready_out, indicators_on_out, turn_count_out[13:0]}, 16'h0, "reset flags");
    nrst_in = 1'h1;
    wait_cyc(4);
    chk(ready_out, 16'h1, "ready");
    chk(indicators_on_out, 16'h0, "power-up blank");
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk_in);
    n_fail++;
    close_out();
  end
  initial begin
    ref_clk_in = 1'h0;
    nrst_in = 1'h0;
    servo_on_in = 1'h0;
    fieldbus_trace_in = 1'h0;
    cmd = 4'h0;
    cfg_in = '0;
    pwr(1'h0, 16'h3);
    chk(limit_mismatch_alarm_out, 16'h1, "mismatch");
    chk(alarm_code_out, 16'h2, "mismatch code");
    chk(count_signed_out, 16'h0, "bounded count");
    go(4'h2);
    chk({limit_wr_strobe_out, limit_mismatch_alarm_out}, 16'h2, "write taken");
    chk(limit_wr_data_out, 16'h3, "write data");
    go(4'h2);
    chk({limit_wr_reject_out, limit_wr_strobe_out}, 16'h2, "write refused");
    $display("Test limit write done");
    foreach (rows[i]) begin
      ENC.turn(rows[i][16]);
      chk(turn_count_out, rows[i][15:0], "turn count");
    end
    $display("Test wrap done");
    servo_on_in = 1'h1;
    go(4'h1);
    chk({setup_reject_out, setup_ack_out, turn_count_out[13:0]}, 16'h8001, "setup on");
    servo_on_in = 1'h0;
    go(4'h1);
    chk({setup_ack_out, turn_count_out[14:0]}, 16'h8000, "setup off");
    ENC.pins_q.backup_loss = 1'h1;
    ENC.pins_q.checksum_err = 1'h1;
    wait_cyc(8);
    go(4'h4);
    chk({alarm_reset_refused_out, backup_alarm_out, checksum_alarm_out}, 16'h7, "reset");
    go(4'h1);
    chk({backup_alarm_out, checksum_alarm_out}, 16'h0, "setup clears");
    ENC.pins_q.backup_loss = 1'h0;
    ENC.pins_q.checksum_err = 1'h0;
    $display("Test setup and alarms done");
    wait_cyc(20);
    chk(indicators_on_out, 16'h1, "lit");
    fieldbus_trace_in = 1'h1;
    wait_cyc(2);
    chk(indicators_on_out, 16'h0, "trace blank");
    fieldbus_trace_in = 1'h0;
    go(4'h8);
    wait_cyc(1);
    chk(indicators_on_out, 16'h0, "access blank");
    wait_cyc(8);
    chk(indicators_on_out, 16'h1, "relit");
    ENC.pins_q.handheld = 1'h1; // No parameter access while attached
    wait_cyc(8);
    chk(indicators_on_out, 16'h0, "handheld blank");
    ENC.pins_q.handheld = 1'h0;
    $display("Test indicators done");
    ENC.pins_q.monitor_alarm = 1'h1;
    wait_cyc(8);
    go(4'h4);
    go(4'h1);
    chk(monitor_alarm_out, 16'h1, "monitor held");
    ENC.pins_q.monitor_alarm = 1'h0;
    cfg_in.usage_select = 1'h1;
    wait_cyc(2);
    chk(absolute_mode_out, 16'h1, "usage latched");
    pwr(1'h0, 16'h3);
    chk({limit_mismatch_alarm_out, monitor_alarm_out}, 16'h0, "match");
    pwr(1'h0, 16'hffff);
    chk({limit_mismatch_alarm_out, count_signed_out}, 16'h3, "default limit");
    go(4'h2);
    ENC.turn(1'h0);
    chk(turn_count_out, 16'hffff, "signed wrap");
    pwr(1'h1, 16'h5);
    chk({absolute_mode_out, count_signed_out, limit_mismatch_alarm_out}, 16'h2, "incr");
    $display("Test power cycles done");
    close_out();
  end
endmodule
`default_nettype wire
